// *** hw/gbp_pkg.sv ***
// package of register offsets, widths and reset values for the gpio port
package gbp_pkg;
    localparam int          PORT_W          = 8;
    localparam int          ADDR_W          = 8;
    // register offsets on the processor i/o bus
    localparam logic [7:0]  PIN_LEVEL_OFS   = 8'h16;
    localparam logic [7:0]  PIN_DIR_OFS     = 8'h17;
    localparam logic [7:0]  OUT_LATCH_OFS   = 8'h18;
    // same registers in data-space addressing
    localparam logic [7:0]  DS_BASE         = 8'h20;
    // reset values, and the value read from unmapped addresses
    localparam logic [7:0]  PIN_DIR_RST     = 8'h00;
    localparam logic [7:0]  OUT_LATCH_RST   = 8'h00;
    localparam logic [7:0]  RDATA_RST       = 8'h00;
    localparam logic [7:0]  UNMAPPED_RD     = 8'h00;
    localparam logic [7:0]  SYNC_RST        = 8'h00;
    // bus access kinds
    typedef enum logic [2:0] {
        GBP_ACC_IDLE  = 3'b001,
        GBP_ACC_READ  = 3'b010,
        GBP_ACC_WRITE = 3'b100
    } gbp_acc_e;
endpackage

// *** hw/gbp_sync.sv ***
// two-stage synchroniser for the port pin levels
`timescale 1ns/1ps
module gbp_sync (
    input  wire logic                         core_clk,
    input  wire logic                         sys_rst,
    input  wire logic [gbp_pkg::PORT_W-1:0]   async_in,
    output logic      [gbp_pkg::PORT_W-1:0]   sync_out
);
    logic [gbp_pkg::PORT_W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q   <= gbp_pkg::SYNC_RST;
            sync_out <= gbp_pkg::SYNC_RST;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// *** hw/gbp_port.sv ***
// eight-bit bidirectional gpio port with register access
//
// Summary of operation
// - output latch at i/o 0x18 (data 0x38), cleared on reset
// - direction register at i/o 0x17 (data 0x37), reset to all inputs
// - pin level view at i/o 0x16 (data 0x36), read-only, writes ignored
// - each pin uses its own direction and data bit, bits 7..0
// - direction 1 drives latch bit push-pull; direction 0 data 0 floats
// - direction 0 with data 1 enables the pull-up
// - pin levels pass a synchroniser before being readable
// - reset forces all pins high-impedance, even with no clock
`timescale 1ns/1ps
module gbp_port (
    input  wire logic                         core_clk,
    input  wire logic                         sys_rst,
    input  wire logic [gbp_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [7:0]                   reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic      [7:0]                   reg_rdata,
    input  wire logic [gbp_pkg::PORT_W-1:0]   port_pin_in,
    output logic      [gbp_pkg::PORT_W-1:0]   port_pin_out,
    output logic      [gbp_pkg::PORT_W-1:0]   port_pin_oe,
    output logic      [gbp_pkg::PORT_W-1:0]   port_pin_pullup
);
    // ********************************************************
    // register decode
    // ********************************************************

    // true when the address hits offset in i/o or data space
    function automatic logic hit(
        input logic [gbp_pkg::ADDR_W-1:0] addr,
        input logic [7:0]                 ofs
    );
        logic [7:0] alias_ofs;
        alias_ofs = 8'(ofs + gbp_pkg::DS_BASE);       // data-space copy
        hit = (addr == ofs) || (addr == alias_ofs);
    endfunction

    // decoded access kind and register selects
    gbp_pkg::gbp_acc_e          acc;
    logic                       wr_latch;
    logic                       wr_dir;
    logic                       rd_latch;
    logic                       rd_dir;
    logic                       rd_level;

    // software registers and their next values
    logic [gbp_pkg::PORT_W-1:0] output_latch_q;
    logic [gbp_pkg::PORT_W-1:0] output_latch_d;
    logic [gbp_pkg::PORT_W-1:0] pin_direction_q;
    logic [gbp_pkg::PORT_W-1:0] pin_direction_d;

    // synchronised pin levels and next read data
    logic [gbp_pkg::PORT_W-1:0] pin_level_view;
    logic [7:0]                 reg_rdata_d;

    // access kind, write wins if both strobes are high
    always_comb begin
        if (reg_wr) begin
            acc = gbp_pkg::GBP_ACC_WRITE;
        end else if (reg_rd) begin
            acc = gbp_pkg::GBP_ACC_READ;
        end else begin
            acc = gbp_pkg::GBP_ACC_IDLE;
        end
    end

    // write selects; the pin view has none, writes drop
    always_comb begin
        wr_latch = 1'h0;
        wr_dir   = 1'h0;
        if (acc == gbp_pkg::GBP_ACC_WRITE) begin
            if (hit(reg_addr, gbp_pkg::OUT_LATCH_OFS)) begin
                wr_latch = 1'h1;
            end else if (hit(reg_addr, gbp_pkg::PIN_DIR_OFS)) begin
                wr_dir = 1'h1;
            end else begin
                wr_dir = 1'h0;
            end
        end
    end

    // read selects, one per mapped register
    always_comb begin
        rd_latch = 1'h0;
        rd_dir   = 1'h0;
        rd_level = 1'h0;
        if (acc == gbp_pkg::GBP_ACC_READ) begin
            if (hit(reg_addr, gbp_pkg::OUT_LATCH_OFS)) begin
                rd_latch = 1'h1;
            end else if (hit(reg_addr, gbp_pkg::PIN_DIR_OFS)) begin
                rd_dir = 1'h1;
            end else if (hit(reg_addr, gbp_pkg::PIN_LEVEL_OFS)) begin
                rd_level = 1'h1;
            end
        end
    end

    // ********************************************************
    // software registers
    // ********************************************************

    // next latch value, so pin flops follow a write at once
    always_comb begin
        output_latch_d = output_latch_q;
        if (wr_latch) begin
            output_latch_d = reg_wdata;
        end
    end

    // next direction value
    always_comb begin
        pin_direction_d = pin_direction_q;
        if (wr_dir) begin
            pin_direction_d = reg_wdata;
        end
    end

    // output latch, cleared by reset
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            output_latch_q <= gbp_pkg::OUT_LATCH_RST;
        end else begin
            output_latch_q <= output_latch_d;
        end
    end

    // direction register, all inputs after reset
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_direction_q <= gbp_pkg::PIN_DIR_RST;
        end else begin
            pin_direction_q <= pin_direction_d;
        end
    end

    // ********************************************************
    // pin input path
    // ********************************************************

    // two flops between the pins and the level view
    gbp_sync u_sync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .async_in (port_pin_in),
        .sync_out (pin_level_view)
    );

    // ********************************************************
    // read path
    // ********************************************************

    // read mux; zero when no read is taken
    always_comb begin
        reg_rdata_d = gbp_pkg::RDATA_RST;
        if (rd_latch) begin
            reg_rdata_d = output_latch_q;
        end else if (rd_dir) begin
            reg_rdata_d = pin_direction_q;
        end else if (rd_level) begin
            reg_rdata_d = pin_level_view;
        end else if (acc == gbp_pkg::GBP_ACC_READ) begin
            reg_rdata_d = gbp_pkg::UNMAPPED_RD;
        end
    end

    // read data register, stands one cycle after the strobe
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= gbp_pkg::RDATA_RST;
        end else begin
            reg_rdata <= reg_rdata_d;
        end
    end

    // ********************************************************
    // pin output path
    // ********************************************************

    // one loop index shared by the three per-pin loops
    genvar i;

    // drive enable per pin, off while reset is held
    generate
        for (i = 0; i < gbp_pkg::PORT_W; i = i + 1) begin : g_oe
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    port_pin_oe[i] <= 1'h0;
                end else begin
                    port_pin_oe[i] <= pin_direction_d[i];
                end
            end
        end
    endgenerate

    // drive value per pin, copy of the latch bit
    generate
        for (i = 0; i < gbp_pkg::PORT_W; i = i + 1) begin : g_out
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    port_pin_out[i] <= 1'h0;
                end else begin
                    port_pin_out[i] <= output_latch_d[i];
                end
            end
        end
    endgenerate

    // pull-up per pin: input direction with latch bit set
    generate
        for (i = 0; i < gbp_pkg::PORT_W; i = i + 1) begin : g_pu
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    port_pin_pullup[i] <= 1'h0;
                end else begin
                    port_pin_pullup[i] <= !pin_direction_d[i] &&
                                          output_latch_d[i];
                end
            end
        end
    endgenerate
endmodule

// *** tb/gbp_props.sv ***
// assertion checker for the gpio port
`timescale 1ns/1ps
module gbp_props (
    input wire logic       core_clk,
    input wire logic       sys_rst,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] port_pin_in,
    input wire logic [7:0] port_pin_out,
    input wire logic [7:0] port_pin_oe,
    input wire logic [7:0] port_pin_pullup
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire lat = reg_addr inside {8'h18, 8'h38};
    wire dir = reg_addr inside {8'h17, 8'h37};
    wire pin = reg_addr inside {8'h16, 8'h36};
    AST_LW: assert property (reg_wr && lat |=>
        port_pin_out == $past(reg_wdata)) else $error("latch write");
    AST_DW: assert property (reg_wr && dir |=>
        port_pin_oe == $past(reg_wdata)) else $error("dir write");
    AST_PU: assert property (port_pin_pullup ==
        (~port_pin_oe & port_pin_out)) else $error("pullup");
    AST_HD: assert property (!(reg_wr && (lat || dir)) |=>
        $stable(port_pin_out) && $stable(port_pin_oe)) else $error("hold");
    AST_RL: assert property (reg_rd && lat |=>
        reg_rdata == port_pin_out) else $error("latch read");
    AST_RD: assert property (reg_rd && dir |=>
        reg_rdata == port_pin_oe) else $error("dir read");
    AST_RP: assert property (reg_rd && pin && !$past(sys_rst) &&
        !$past(sys_rst, 2) |=> reg_rdata == $past(port_pin_in, 3))
        else $error("pin read");
    AST_RZ: assert property (!(reg_rd && (lat||dir||pin)) |=>
        reg_rdata == 8'h00) else $error("idle read");
endmodule

// *** tb/gbp_pins.sv ***
// model of the external circuitry on the port pins
`timescale 1ns/1ps
module gbp_pins (
    input  wire logic       core_clk,
    input  wire logic [7:0] oe,
    input  wire logic [7:0] dout,
    input  wire logic [7:0] pu,
    input  wire logic [7:0] en,
    input  wire logic [7:0] val,
    output logic      [7:0] lvl
);
    logic [7:0] f_q = 8'h00;
    // open pins without pull-up toggle every cycle
    always @(posedge core_clk) f_q <= ~f_q;
    // device drive wins, pulled-up pins read high, other open pins wander
    assign lvl = oe & dout | ~oe & (en & val | ~en & (pu | f_q));
endmodule

// *** tb/gbp_port_tb.sv ***
// self-checking bench for the gpio port
`timescale 1ns/1ps
module gbp_port_tb;
    logic       core_clk  = 1'h0;
    logic       sys_rst   = 1'h1;
    logic       reg_wr    = 1'h0;
    logic       reg_rd    = 1'h0;
    logic [7:0] reg_addr  = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [7:0] port_pin_in;
    logic [7:0] port_pin_out;
    logic [7:0] port_pin_oe;
    logic [7:0] port_pin_pullup;
    int         bad_count = 0;
    int         tests_run = 0;

    // 50 ns clock
    always #25 core_clk = ~core_clk;

    // device under test
    gbp_port dut (
        .core_clk        (core_clk),
        .sys_rst         (sys_rst),
        .reg_addr        (reg_addr),
        .reg_wdata       (reg_wdata),
        .reg_wr          (reg_wr),
        .reg_rd          (reg_rd),
        .reg_rdata       (reg_rdata),
        .port_pin_in     (port_pin_in),
        .port_pin_out    (port_pin_out),
        .port_pin_oe     (port_pin_oe),
        .port_pin_pullup (port_pin_pullup)
    );

    // pins: bit 0 held high, bit 1 held low, the rest open
    gbp_pins u_pins (
        .core_clk (core_clk),
        .oe       (port_pin_oe),
        .dout     (port_pin_out),
        .pu       (port_pin_pullup),
        .en       (8'h03),
        .val      (8'h01),
        .lvl      (port_pin_in)
    );

    // compare one value, count and report a mismatch
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h want %h", $time, seen, exp);
        end
    endtask

    // one bus access; a read checks the data in the cycle after it
    task automatic acc(input logic       w,
                       input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= w;
        reg_rd    <= !w;
        reg_addr  <= a;
        reg_wdata <= w ? d : 8'h00;
        @(posedge core_clk);
        reg_wr <= 1'h0;
        reg_rd <= 1'h0;
        #1;
        if (!w) begin
            chk(reg_rdata, d);
        end
    endtask

    // idle cycles, lets pin levels cross the synchroniser
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // verdict and end of run
    task automatic tally_and_finish;
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (3000) @(posedge core_clk);
        bad_count++;
        tally_and_finish;
    end

    // test sequence
    initial begin
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'h0;
        acc(1'h0, 8'h18, 8'h00);
        acc(1'h0, 8'h37, 8'h00);
        acc(1'h1, 8'h37, 8'hF0);
        acc(1'h1, 8'h18, 8'hCC);
        chk(port_pin_oe, 8'hF0);
        chk(port_pin_out, 8'hCC);
        chk(port_pin_pullup, 8'h0C);
        idle(1);
        acc(1'h0, 8'h16, 8'hCD);
        acc(1'h1, 8'h36, 8'hAA);
        acc(1'h0, 8'h38, 8'hCC);
        acc(1'h1, 8'h17, 8'hFF);
        chk(port_pin_pullup, 8'h00);
        idle(1);
        acc(1'h0, 8'h36, 8'hCC);
        acc(1'h0, 8'h19, 8'h00);
        @(posedge core_clk);
        sys_rst <= 1'h1;
        #1;
        chk(port_pin_oe | port_pin_pullup, 8'h00);
        chk(port_pin_out, 8'h00);
        @(posedge core_clk);
        sys_rst <= 1'h0;
        acc(1'h0, 8'h18, 8'h00);
        acc(1'h0, 8'h17, 8'h00);
        tally_and_finish;
    end
endmodule

bind gbp_port gbp_props u_props (
    .core_clk        (core_clk),
    .sys_rst         (sys_rst),
    .reg_wr          (reg_wr),
    .reg_rd          (reg_rd),
    .reg_addr        (reg_addr),
    .reg_wdata       (reg_wdata),
    .reg_rdata       (reg_rdata),
    .port_pin_in     (port_pin_in),
    .port_pin_out    (port_pin_out),
    .port_pin_oe     (port_pin_oe),
    .port_pin_pullup (port_pin_pullup)
);
